// *** hdl/bitband_map.sv ***
`timescale 1ns/100ps
`default_nettype none

module bitband_map
  import sysdec_pkg::*;
(
  input  wire logic [31:0] addr,
  output logic             isAlias,
  output logic [31:0]      physAddr,
  output logic [4:0]       bitIdx
);

  wire logic        sramHit;
  wire logic        periHit;
  wire logic [31:0] wordOff;
  wire logic [31:0] aliasBase;

  assign sramHit   = (addr & ~BB_SRAM_SPAN) == BB_SRAM_ALIAS;
  assign periHit   = (addr & ~BB_PERI_SPAN) == BB_PERI_ALIAS;
  // each alias word stands for one bit: 32 alias bytes per target byte
  assign wordOff   = {12'h000, addr[24:7], 2'b00};
  assign aliasBase = sramHit ? BB_SRAM_BASE : BB_PERI_BASE;
  assign isAlias   = sramHit | periHit;
  assign physAddr  = aliasBase | wordOff;
  assign bitIdx    = addr[6:2];

endmodule : bitband_map

`default_nettype wire

// *** hdl/region_lookup.sv ***
`timescale 1ns/100ps
`default_nettype none

module region_lookup
  import sysdec_pkg::*;
(
  input  wire logic [31:0]         addr,
  output logic      [NTGT-1:0]     hit,
  output logic                     miss,
  output logic      [OFFSET_W-1:0] offset
);

  logic [OFFSET_W-1:0] part [NTGT];
  logic [OFFSET_W-1:0] acc  [NTGT+1];

  assign acc[0] = '0;

  genvar i;
  generate
    for (i = 0; i < NTGT; i = i + 1) begin : g_win
      localparam logic [31:0] MASK = TGT_IS_FLASH[i] ? WIN_16K : WIN_4K;
      // upper bits select the window, the rest is the local offset
      assign hit[i]   = (addr & ~MASK) == TGT_BASE[i];
      assign part[i]  = hit[i] ? addr[OFFSET_W-1:0] & MASK[OFFSET_W-1:0] : '0;
      assign acc[i+1] = acc[i] | part[i];
    end
  endgenerate

  assign offset = acc[NTGT];
  assign miss   = ~|hit;

endmodule : region_lookup

`default_nettype wire

// *** hdl/system_address_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none

// Function
// - one fixed 4 GB byte map, never remapped while running.
// - any access into reserved space ends with a bus fault.
// - little-endian lanes for word, halfword and byte transfers.
// - flash answers 0x0000_0000-0x0000_3FFF; rest of code region reserved.
// - sram answers 0x2000_0000-0x2000_0FFF; rest of sram region reserved.
// - sram alias window maps each word onto one sram bit, atomically.
// - peripheral alias window maps each word onto one peripheral bit.
// - watchdog at 0x4000_0000; following range up to port A reserved.
// - four 4 KB windows from 0x4000_4000 select ports A to D.
// - serial port, two uarts and i2c windows; gaps reserved.
// - port E at 0x4002_4000; surroundings reserved.
// - pwm at 0x4002_8000 and three timers from 0x4003_0000.
// - adc at 0x4003_8000, comparators at 0x4003_C000; gaps reserved.
// - flash controller at 0x400F_D000; gap before it reserved.
// - system control at 0x400F_E000; space up to alias reserved.
// - trace unit, watchpoint unit, patch unit from 0xE000_0000.
// - core peripheral window at 0xE000_E000.
// - trace port at 0xE004_0000; everything above reserved.
// - each target sees only its local offset within its window.
// - peripheral accesses stay in program order and never execute.
module system_address_decoder
  import sysdec_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                mReq,
  input  wire logic                mWrite,
  input  wire logic                mInstr,
  input  wire logic [1:0]          mSize,
  input  wire logic [31:0]         mAddr,
  input  wire logic [31:0]         mWdata,
  output logic                     mBusy,
  output logic                     mDone,
  output logic                     mFault,
  output logic      [31:0]         mRdata,
  output logic      [NTGT-1:0]     tgtSel,
  output logic                     tgtReq,
  output logic                     tgtWrite,
  output logic                     tgtDevice,
  output logic      [3:0]          tgtByteEn,
  output logic      [OFFSET_W-1:0] tgtOffset,
  output logic      [31:0]         tgtWdata,
  input  wire logic [31:0]         tgtRdata,
  input  wire logic                tgtDone
);

  ////////////////////////////////////////////////////////////////////////////
  // address translation and window decode

  wire logic                isAlias;
  wire logic [31:0]         aliasPhys;
  wire logic [4:0]          aliasBit;
  wire logic [31:0]         effAddr;
  wire logic [NTGT-1:0]     hit;
  wire logic                miss;
  wire logic [OFFSET_W-1:0] offset;

  bitband_map u_bitband (
    .addr     (mAddr),
    .isAlias  (isAlias),
    .physAddr (aliasPhys),
    .bitIdx   (aliasBit)
  );

  // alias accesses are decoded at the word that holds the bit
  assign effAddr = isAlias ? aliasPhys : mAddr;

  // the table is constant: no window ever moves
  region_lookup u_lookup (
    .addr   (effAddr),
    .hit    (hit),
    .miss   (miss),
    .offset (offset)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request checks

  wire logic misaligned;
  wire logic badSize;
  wire logic xnFetch;
  wire logic reqFault;

  assign misaligned = (mSize == SIZE_HALF && mAddr[0]) ||
                      (mSize == SIZE_WORD && mAddr[1:0] != 2'h0);
  assign badSize    = mSize == 2'h3;
  // fetches only from code-bearing windows, never from device space
  assign xnFetch    = mInstr && (isAlias || ~|(hit & TGT_EXEC));
  // reserved holes in every region land in miss
  assign reqFault   = miss | misaligned | badSize | xnFetch;

  ////////////////////////////////////////////////////////////////////////////
  // little-endian lane steering

  wire logic [3:0]  byteOne;
  wire logic [3:0]  laneEn;
  wire logic [31:0] laneWdata;

  assign byteOne   = 4'h1 << mAddr[1:0];
  assign laneEn    = isAlias             ? 4'hF :
                     mSize == SIZE_BYTE  ? byteOne :
                     mSize == SIZE_HALF  ? (mAddr[1] ? 4'hC : 4'h3) :
                                           4'hF;
  assign laneWdata = mSize == SIZE_BYTE ? {4{mWdata[7:0]}} :
                     mSize == SIZE_HALF ? {2{mWdata[15:0]}} :
                                          mWdata;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  state_t     state;
  state_t     next_state;
  logic       reqWrite;
  logic [1:0] reqSize;
  logic [1:0] reqLane;
  logic [4:0] reqBit;
  logic       reqSet;

  wire logic reqTaken;
  wire logic inIdle;

  assign inIdle   = state == ST_IDLE;
  // one transfer in flight at a time keeps device accesses in order
  assign reqTaken = inIdle && mReq;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (reqTaken && !reqFault) begin
          next_state = isAlias ? ST_BB_READ : ST_XFER;
        end
      end
      ST_XFER: begin
        if (tgtDone) begin
          next_state = ST_IDLE;
        end
      end
      ST_BB_READ: begin
        if (tgtDone) begin
          next_state = reqWrite ? ST_BB_ARM : ST_IDLE;
        end
      end
      ST_BB_ARM: begin
        next_state = ST_BB_WRITE;
      end
      ST_BB_WRITE: begin
        if (tgtDone) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // captured request attributes

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqWrite <= 1'b0;
      reqSize  <= SIZE_BYTE;
      reqLane  <= 2'h0;
      reqBit   <= 5'h00;
      reqSet   <= 1'b0;
    end else if (reqTaken) begin
      reqWrite <= mWrite;
      reqSize  <= mSize;
      reqLane  <= mAddr[1:0];
      reqBit   <= aliasBit;
      reqSet   <= mWdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and bit merge

  wire logic [31:0] shifted;
  wire logic [31:0] readValue;
  wire logic [31:0] bitMask;
  wire logic [31:0] mergedWord;
  wire logic        lastDone;
  wire logic        bbReadDone;

  assign shifted    = tgtRdata >> {reqLane, 3'b000};
  assign readValue  = reqSize == SIZE_BYTE ? {24'h00_0000, shifted[7:0]} :
                      reqSize == SIZE_HALF ? {16'h0000, shifted[15:0]} :
                                             shifted;
  assign bitMask    = 32'h0000_0001 << reqBit;
  assign mergedWord = reqSet ? (tgtRdata | bitMask) : (tgtRdata & ~bitMask);
  assign bbReadDone = state == ST_BB_READ && tgtDone;
  assign lastDone   = tgtDone && (state == ST_XFER || state == ST_BB_WRITE ||
                                  (bbReadDone && !reqWrite));

  ////////////////////////////////////////////////////////////////////////////
  // target side

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgtReq <= 1'b0;
    end else if (reqTaken && !reqFault) begin
      tgtReq <= 1'b1;
    end else if (state == ST_BB_ARM) begin
      tgtReq <= 1'b1;
    end else if (tgtDone) begin
      tgtReq <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgtSel    <= '0;
      tgtDevice <= 1'b0;
      tgtOffset <= '0;
      tgtByteEn <= 4'h0;
    end else if (reqTaken && !reqFault) begin
      tgtSel    <= hit;
      tgtDevice <= |(hit & TGT_DEVICE);
      tgtOffset <= offset;
      tgtByteEn <= laneEn;
    end else if (lastDone) begin
      tgtSel    <= '0;
      tgtDevice <= 1'b0;
      tgtByteEn <= 4'h0;
    end
  end

  // an alias write first reads the word, then writes it back merged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgtWrite <= 1'b0;
      tgtWdata <= 32'h0000_0000;
    end else if (reqTaken && !reqFault) begin
      tgtWrite <= mWrite && !isAlias;
      tgtWdata <= laneWdata;
    end else if (bbReadDone && reqWrite) begin
      tgtWrite <= 1'b1;
      tgtWdata <= mergedWord;
    end else if (lastDone) begin
      tgtWrite <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master side answer

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mBusy <= 1'b0;
    end else if (reqTaken && !reqFault) begin
      mBusy <= 1'b1;
    end else if (lastDone) begin
      mBusy <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mDone  <= 1'b0;
      mFault <= 1'b0;
    end else begin
      mDone  <= (reqTaken && reqFault) || lastDone;
      mFault <= reqTaken && reqFault;
    end
  end

  // a fault returns zero data; the master must not use it anyway
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mRdata <= 32'h0000_0000;
    end else if (reqTaken && reqFault) begin
      mRdata <= 32'h0000_0000;
    end else if (bbReadDone && !reqWrite) begin
      mRdata <= {31'h0000_0000, tgtRdata[reqBit]};
    end else if (lastDone) begin
      mRdata <= reqWrite ? 32'h0000_0000 : readValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the remaining windows come straight from the constant
  // table in the lookup; no further logic distinguishes them here

endmodule : system_address_decoder

`default_nettype wire

// *** shared/sysdec_pkg.sv ***
package sysdec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus widths and transfer sizes
  localparam int          ADDR_W    = 32;
  localparam int          DATA_W    = 32;
  localparam int          OFFSET_W  = 14;
  localparam logic [1:0]  SIZE_BYTE = 2'h0;
  localparam logic [1:0]  SIZE_HALF = 2'h1;
  localparam logic [1:0]  SIZE_WORD = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // target indices
  localparam int NTGT          = 25;
  localparam int TGT_FLASH     = 0;
  localparam int TGT_SRAM      = 1;
  localparam int TGT_WATCHDOG  = 2;
  localparam int TGT_GPIO_A    = 3;
  localparam int TGT_GPIO_B    = 4;
  localparam int TGT_GPIO_C    = 5;
  localparam int TGT_GPIO_D    = 6;
  localparam int TGT_SYNC_SER  = 7;
  localparam int TGT_UART0     = 8;
  localparam int TGT_UART1     = 9;
  localparam int TGT_I2C       = 10;
  localparam int TGT_GPIO_E    = 11;
  localparam int TGT_PWM       = 12;
  localparam int TGT_TIMER0    = 13;
  localparam int TGT_TIMER1    = 14;
  localparam int TGT_TIMER2    = 15;
  localparam int TGT_ADC       = 16;
  localparam int TGT_COMPARE   = 17;
  localparam int TGT_FLASH_CTL = 18;
  localparam int TGT_SYS_CTL   = 19;
  localparam int TGT_TRACE     = 20;
  localparam int TGT_WATCHPT   = 21;
  localparam int TGT_PATCH_BKP = 22;
  localparam int TGT_CORE_PERI = 23;
  localparam int TGT_TRACE_PRT = 24;

  ////////////////////////////////////////////////////////////////////////////
  // window bases and offset masks, indexed by target
  localparam logic [31:0] WIN_4K   = 32'h0000_0FFF;
  localparam logic [31:0] WIN_16K  = 32'h0000_3FFF;
  localparam logic [31:0] TGT_BASE [NTGT] = '{
    32'h0000_0000, 32'h2000_0000, 32'h4000_0000, 32'h4000_4000, 32'h4000_5000,
    32'h4000_6000, 32'h4000_7000, 32'h4000_8000, 32'h4000_C000, 32'h4000_D000,
    32'h4002_0000, 32'h4002_4000, 32'h4002_8000, 32'h4003_0000, 32'h4003_1000,
    32'h4003_2000, 32'h4003_8000, 32'h4003_C000, 32'h400F_D000, 32'h400F_E000,
    32'hE000_0000, 32'hE000_1000, 32'hE000_2000, 32'hE000_E000, 32'hE004_0000};
  localparam logic [NTGT-1:0] TGT_IS_FLASH = 25'h000_0001;
  // only flash and sram hold code; device windows never execute
  localparam logic [NTGT-1:0] TGT_EXEC     = 25'h000_0003;
  // device and strongly ordered windows
  localparam logic [NTGT-1:0] TGT_DEVICE   = 25'h1FF_FFFC;

  ////////////////////////////////////////////////////////////////////////////
  // bit-band alias windows
  localparam logic [31:0] BB_SRAM_ALIAS = 32'h2200_0000;
  localparam logic [31:0] BB_SRAM_SPAN  = 32'h0001_FFFF;
  localparam logic [31:0] BB_SRAM_BASE  = 32'h2000_0000;
  localparam logic [31:0] BB_PERI_ALIAS = 32'h4200_0000;
  localparam logic [31:0] BB_PERI_SPAN  = 32'h01FF_FFFF;
  localparam logic [31:0] BB_PERI_BASE  = 32'h4000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_XFER     = 5'h02,
    ST_BB_READ  = 5'h04,
    ST_BB_ARM   = 5'h08,
    ST_BB_WRITE = 5'h10
  } state_t;

endpackage : sysdec_pkg

// *** tb/system_address_decoder_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module system_address_decoder_properties
  import sysdec_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                mReq,
  input wire logic                mInstr,
  input wire logic [1:0]          mSize,
  input wire logic [31:0]         mAddr,
  input wire logic                mBusy,
  input wire logic                mDone,
  input wire logic                mFault,
  input wire logic [31:0]         mRdata,
  input wire logic [NTGT-1:0]     tgtSel,
  input wire logic                tgtReq,
  input wire logic                tgtWrite,
  input wire logic                tgtDevice,
  input wire logic [3:0]          tgtByteEn,
  input wire logic [OFFSET_W-1:0] tgtOffset,
  input wire logic [31:0]         tgtWdata,
  input wire logic                tgtDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] tAddr;
  logic [1:0]  tSize;
  wire take = mReq && !mBusy;
  wire resv = (mAddr >= 32'h0000_4000 && mAddr < 32'h2000_0000) ||
              (mAddr >= 32'h4400_0000 && mAddr < 32'hE000_0000) || mAddr >= 32'hE004_1000;
  wire isAl = tAddr[31:24] == 8'h22 || tAddr[31:25] == 7'h21;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tAddr <= 32'h0;
      tSize <= 2'h0;
    end else if (take) begin
      tAddr <= mAddr;
      tSize <= mSize;
    end
  end
  a_reserved_fault: assert property (take && resv |=> mDone && mFault && mRdata == 32'h0 && !tgtReq)
    else $error("reserved access not faulted");
  a_fetch_never: assert property (take && mInstr && mAddr[31:30] == 2'h1 |=> mDone && mFault)
    else $error("peripheral fetch not faulted");
  a_misalign_fault: assert property (take && mSize == SIZE_WORD && mAddr[1:0] != 2'h0 |=> mFault)
    else $error("misaligned word not faulted");
  a_target_stable: assert property (tgtReq && !tgtDone |=> tgtReq && $stable(tgtSel)
    && $stable(tgtOffset) && $stable(tgtByteEn) && $stable(tgtWdata))
    else $error("target request changed early");
  a_done_follows: assert property (tgtReq && tgtDone |=> !tgtReq && (mDone || tgtWrite))
    else $error("bad step after target done");
  a_onehot_sel: assert property (tgtReq |-> $onehot(tgtSel))
    else $error("target select not one-hot");
  a_device_attr: assert property (tgtReq |-> tgtDevice == !(tgtSel[TGT_FLASH] || tgtSel[TGT_SRAM]))
    else $error("device attribute wrong");
  a_offset_pass: assert property (tgtReq && !isAl && !tgtSel[TGT_FLASH]
    |-> tgtOffset == {2'h0, tAddr[11:0]})
    else $error("local offset wrong");
  a_port_window: assert property (tgtReq && !isAl && tAddr[31:12] == 20'h40004 |-> tgtSel[TGT_GPIO_A])
    else $error("port A window not selected");
  a_byte_lane: assert property (tgtReq && !isAl && tSize == SIZE_BYTE |-> tgtByteEn == 4'h1 << tAddr[1:0])
    else $error("byte lane wrong");
  a_busy_hold: assert property (tgtReq |-> mBusy && !mDone)
    else $error("busy not held during target request");
  c_fault: cover property (take ##1 mFault);
  c_alias_write: cover property (tgtReq && tgtWrite && isAl);
  c_ok_done: cover property (mDone && !mFault);
endmodule : system_address_decoder_properties
bind system_address_decoder system_address_decoder_properties system_address_decoder_properties_inst (
  .clk(clk), .rst_n(rst_n), .mReq(mReq), .mInstr(mInstr), .mSize(mSize), .mAddr(mAddr), .mBusy(mBusy),
  .mDone(mDone), .mFault(mFault), .mRdata(mRdata), .tgtSel(tgtSel), .tgtReq(tgtReq), .tgtWrite(tgtWrite),
  .tgtDevice(tgtDevice), .tgtByteEn(tgtByteEn), .tgtOffset(tgtOffset), .tgtWdata(tgtWdata), .tgtDone(tgtDone));
`default_nettype wire

// *** tb/system_address_decoder_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin badCount++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module system_address_decoder_tb_top
  import sysdec_pkg::*;
;
  typedef struct {logic [31:0] a; logic [1:0] s; int t;} row_t;
  logic                clk, rst_n, mReq, mWrite, mInstr, mBusy, mDone, mFault;
  logic                tgtReq, tgtWrite, tgtDevice, tgtDone, sDev;
  logic [1:0]          mSize, lat;
  logic [31:0]         mAddr, mWdata, mRdata, tgtRdata, tgtWdata;
  logic [NTGT-1:0]     tgtSel, sSel;
  logic [3:0]          tgtByteEn, sBe;
  logic [OFFSET_W-1:0] tgtOffset, sOff;
  int                  badCount, checkCount, cycles;
  row_t rows [$] = '{'{32'h0000_0000,2'h2,0}, '{32'h0000_3FFE,2'h1,0}, '{32'h0000_4000,2'h2,-1},
    '{32'h1FFF_FFFC,2'h2,-1}, '{32'h2000_0FFF,2'h0,1}, '{32'h2000_1000,2'h2,-1}, '{32'h2202_0000,2'h2,-1},
    '{32'h4000_0FFE,2'h1,2}, '{32'h4000_1000,2'h2,-1}, '{32'h4000_5000,2'h2,4}, '{32'h4000_6001,2'h0,5},
    '{32'h4000_7FFC,2'h2,6}, '{32'h4000_8000,2'h2,7}, '{32'h4000_9000,2'h2,-1}, '{32'h4000_C000,2'h2,8},
    '{32'h4000_DFFC,2'h2,9}, '{32'h4000_E000,2'h2,-1}, '{32'h4002_0000,2'h2,10}, '{32'h4002_1000,2'h2,-1},
    '{32'h4002_4FFC,2'h2,11}, '{32'h4002_5000,2'h2,-1}, '{32'h4002_8000,2'h2,12}, '{32'h4002_9000,2'h2,-1},
    '{32'h4003_0000,2'h2,13}, '{32'h4003_1000,2'h2,14}, '{32'h4003_2FFC,2'h2,15}, '{32'h4003_3000,2'h2,-1},
    '{32'h4003_8000,2'h2,16}, '{32'h4003_9000,2'h2,-1}, '{32'h4003_C000,2'h2,17}, '{32'h4003_D000,2'h2,-1},
    '{32'h400F_D000,2'h2,18}, '{32'h400F_E000,2'h2,19}, '{32'h400F_F000,2'h2,-1}, '{32'hE000_0000,2'h2,20},
    '{32'hE000_1000,2'h2,21}, '{32'hE000_2FFC,2'h2,22}, '{32'hE000_3000,2'h2,-1}, '{32'hE000_E000,2'h2,23},
    '{32'hE000_F000,2'h2,-1}, '{32'hE004_0FFC,2'h2,24}, '{32'hE004_1000,2'h2,-1}, '{32'hFFFF_FFFC,2'h2,-1},
    '{32'h6000_0000,2'h2,-1}};
  system_address_decoder system_address_decoder_inst (.clk(clk), .rst_n(rst_n), .mReq(mReq), .mWrite(mWrite),
    .mInstr(mInstr), .mSize(mSize), .mAddr(mAddr), .mWdata(mWdata), .mBusy(mBusy), .mDone(mDone),
    .mFault(mFault), .mRdata(mRdata), .tgtSel(tgtSel), .tgtReq(tgtReq), .tgtWrite(tgtWrite),
    .tgtDevice(tgtDevice), .tgtByteEn(tgtByteEn), .tgtOffset(tgtOffset), .tgtWdata(tgtWdata),
    .tgtRdata(tgtRdata), .tgtDone(tgtDone));
  target_model target_model_inst (.clk(clk), .rst_n(rst_n), .tgtReq(tgtReq), .tgtWrite(tgtWrite),
    .tgtByteEn(tgtByteEn), .tgtOffset(tgtOffset), .tgtWdata(tgtWdata), .lat(lat), .tgtRdata(tgtRdata),
    .tgtDone(tgtDone));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // one master transfer; request released after its take edge, then wait for completion
  task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic w, input logic i, input logic [31:0] d);
    int n;
    @(negedge clk);
    {mReq, mAddr, mSize, mWrite, mInstr, mWdata} = {1'b1, a, s, w, i, d};
    @(negedge clk);
    mReq = 1'b0;
    sSel = '0;
    n = 0;
    while (mDone !== 1'b1 && n < 50) begin
      if (tgtReq === 1'b1) {sSel, sOff, sBe, sDev} = {tgtSel, tgtOffset, tgtByteEn, tgtDevice};
      @(negedge clk);
      n++;
    end
    if (n == 50) badCount++;
  endtask : acc
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      summarize();
    end
  end
  initial begin
    {rst_n, mReq, mWrite, mInstr, mSize, mAddr, mWdata, lat} = '0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    `CHK("idle", 60'h0, {mBusy, mDone, tgtReq, tgtSel, mRdata})
    foreach (rows[i]) begin
      lat = 2'(i % 3);
      acc(rows[i].a, rows[i].s, 1'b0, 1'b0, 32'h0);
      `CHK("fault", rows[i].t < 0, mFault)
      if (rows[i].t >= 0) begin
        `CHK("sel", 25'h1 << rows[i].t, sSel)
        `CHK("off", rows[i].t == 0 ? rows[i].a[13:0] : {2'h0, rows[i].a[11:0]}, sOff)
        `CHK("be", rows[i].s == 2'h0 ? 4'h1 << rows[i].a[1:0] : rows[i].s == 2'h1 ? 4'h3 << rows[i].a[1:0] : 4'hF,
          sBe)
        `CHK("dev", rows[i].t > 1, sDev)
      end
    end
    lat = 2'h1;
    acc(32'h4000_4004, SIZE_WORD, 1'b1, 1'b0, 32'h4433_2211);
    acc(32'h4000_4005, SIZE_BYTE, 1'b1, 1'b0, 32'h0000_00AB);
    acc(32'h4000_4006, SIZE_BYTE, 1'b0, 1'b0, 32'h0);
    `CHK("rdb", 32'h33, mRdata)
    acc(32'h4000_4006, SIZE_HALF, 1'b0, 1'b0, 32'h0);
    `CHK("rdh", 32'h4433, mRdata)
    acc(32'h4208_008C, SIZE_WORD, 1'b1, 1'b0, 32'h1);
    acc(32'h4000_4004, SIZE_WORD, 1'b0, 1'b0, 32'h0);
    `CHK("pbit", 32'h4433_AB19, mRdata)
    acc(32'h2200_0084, SIZE_WORD, 1'b0, 1'b0, 32'h0);
    `CHK("sbit0", 32'h0, mRdata)
    lat = 2'h0;
    acc(32'h2200_0084, SIZE_WORD, 1'b1, 1'b0, 32'h1);
    acc(32'h2200_0084, SIZE_WORD, 1'b0, 1'b0, 32'h0);
    `CHK("sbit1", 32'h1, mRdata)
    acc(32'h4000_4004, SIZE_WORD, 1'b0, 1'b0, 32'h0);
    `CHK("word", 32'h4433_AB1B, mRdata)
    acc(32'h4000_4000, 2'h3, 1'b0, 1'b0, 32'h0);
    `CHK("sz3", 1'b1, mFault)
    acc(32'h4000_4001, SIZE_HALF, 1'b0, 1'b0, 32'h0);
    `CHK("mish", 1'b1, mFault)
    `CHK("frd", 32'h0, mRdata)
    acc(32'h4000_4000, SIZE_WORD, 1'b0, 1'b1, 32'h0);
    `CHK("xn", 1'b1, mFault)
    acc(32'h0000_0100, SIZE_WORD, 1'b0, 1'b1, 32'h0);
    `CHK("fetch", 2'h0, {mFault, sDev})
    // reset pulled while a transfer is in flight
    lat = 2'h2;
    @(negedge clk);
    {mReq, mAddr, mSize, mWrite, mInstr} = {1'b1, 32'h4000_4004, SIZE_WORD, 1'b0, 1'b0};
    @(negedge clk);
    mReq = 1'b0;
    `CHK("busy", 2'h3, {mBusy, tgtReq})
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    `CHK("rst", 60'h0, {mBusy, mDone, tgtReq, tgtSel, mRdata})
    acc(32'h4000_4004, SIZE_WORD, 1'b0, 1'b0, 32'h0);
    `CHK("after", 2'h2, {mDone, mFault})
    `CHK("asel", 25'h1 << TGT_GPIO_A, sSel)
    summarize();
  end
endmodule : system_address_decoder_tb_top
`default_nettype wire

// *** tb/target_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module target_model
  import sysdec_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                tgtReq,
  input  wire logic                tgtWrite,
  input  wire logic [3:0]          tgtByteEn,
  input  wire logic [OFFSET_W-1:0] tgtOffset,
  input  wire logic [31:0]         tgtWdata,
  input  wire logic [1:0]          lat,
  output logic      [31:0]         tgtRdata,
  output logic                     tgtDone
);
  logic [31:0] mem [16];
  logic [31:0] last;
  logic [2:0]  cnt;
  logic [3:0]  idx;
  // one small word store shared by all windows, reached by local offset only
  assign idx = tgtOffset[5:2];
  assign tgtDone = tgtReq && (cnt == {1'b0, lat});
  // released data lines show the inverse of the last value
  assign tgtRdata = tgtReq ? mem[idx] : ~last;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
      last <= 32'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 32'h0;
    end else begin
      cnt <= tgtReq ? cnt + 3'h1 : 3'h0;
      if (tgtReq) last <= tgtRdata;
      for (int b = 0; b < 4; b++)
        if (tgtDone && tgtWrite && tgtByteEn[b]) mem[idx][8*b+:8] <= tgtWdata[8*b+:8];
    end
  end
endmodule : target_model
`default_nettype wire
